// ===== rtl/frm_manager.sv
// Fault response, restart, latch and summary status logic for one channel
`timescale 1ns/1ps
`include "frm_defs.svh"

module frm_manager (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire frm_pkg::frm_fault_t fault_in,
  input wire logic vout_ov_fault_in,
  input wire logic cml_fault_in,
  input wire logic busy_in,
  input wire logic seq_off_mode_in,
  input wire logic [15:0] toff_delay_cyc_in,
  input wire logic [2:0] retry_limit_in,
  input wire logic op_on_in,
  input wire logic op_wr_in,
  input wire logic on_off_cfg_wr_in,
  input wire logic clear_faults_in,
  input wire logic channel_on_pin_in,
  input wire logic bias_sense_pin_in,
  input wire logic power_good_pin_in,
  input wire logic reg_wr_in,
  input wire logic [2:0] reg_sel_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic chan_en_out,
  output logic fault_latched_out,
  output logic [15:0] status_word_out,
  output logic [7:0] status_input_out,
  output logic [7:0] status_temp_out,
  output logic [7:0] status_vout_out,
  output logic alert_out_n
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] cfg [0:`FRM_NUM_CFG-1]; // Response configuration bytes
  logic [4:0] fault_vec; // Faults indexed like the selects
  logic [4:0] shut_vec; // Faults whose action asks for shutdown
  logic shut; // Any shutting fault this cycle
  logic [2:0] shut_retry; // Retry field of the winning fault
  logic [2:0] pin_s1; // First synchroniser stage
  logic [2:0] pin_s2; // Second synchroniser stage
  logic [2:0] pin_prev; // Previous synchronised value
  logic on_pin; // Synchronised channel control pin
  logic bias_ok; // Synchronised bias sense
  logic pg_ok; // Synchronised power good
  logic cmd_on; // Channel commanded on with bias
  logic release_latch; // Event that frees a latched fault
  frm_pkg::frm_state_t state; // Channel state
  frm_pkg::frm_state_t next_state;
  logic [15:0] cnt; // Turn-off or retry wait count
  logic [15:0] next_cnt;
  logic [2:0] attempts; // Restart attempts made
  logic [2:0] next_attempts;
  logic [2:0] retry_sel; // Retry field captured at shutdown
  logic [2:0] next_retry_sel;
  logic next_chan_en;
  frm_pkg::frm_sticky_t sticky; // Sticky status flags
  frm_pkg::frm_sticky_t next_sticky;
  logic [7:0] summary; // Summary status byte
  logic [15:0] next_word;
  logic [7:0] next_input;
  logic [7:0] next_temp;
  logic [7:0] next_vout;
  logic [7:0] next_rdata;
  logic next_alert_n;

  // ----------------------------------------------------------------
  // Response configuration bytes
  // ----------------------------------------------------------------
  // One register per response, all with the same layout
  for (genvar gi = 0; gi < `FRM_NUM_CFG; gi++) begin : g_cfg
    frm_cfg_reg #(
      .SEL(3'(gi))
    ) u_cfg (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .wr_in(reg_wr_in),
      .sel_in(reg_sel_in),
      .wdata_in(reg_wdata_in),
      .cfg_out(cfg[gi])
    );
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two flops per pin, then one more for edge detection
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_prev <= 3'h0;
    end else begin
      pin_s1 <= {power_good_pin_in, bias_sense_pin_in, channel_on_pin_in};
      pin_s2 <= pin_s1;
      pin_prev <= pin_s2;
    end
  end

  assign on_pin = pin_s2[0];
  assign bias_ok = pin_s2[1];
  assign pg_ok = pin_s2[2];
  assign cmd_on = on_pin && op_on_in && bias_ok;

  // Pin toggle, on/off commands or bias reapplied free the latch
  assign release_latch = (pin_s2[0] != pin_prev[0]) || op_wr_in ||
                         on_off_cfg_wr_in || (pin_s2[1] && !pin_prev[1]);

  // ----------------------------------------------------------------
  // Fault decode
  // ----------------------------------------------------------------
  // Faults act at once; no filtering stage in between
  assign fault_vec = {fault_in.ton_max, fault_in.vin_uv, fault_in.vin_ov,
                      fault_in.ut, fault_in.ot};

  // Pick shutting faults and the retry field of the lowest index
  always_comb begin
    shut_vec = 5'h00;
    shut_retry = 3'h0;
    for (int i = `FRM_NUM_CFG - 1; i >= 0; i--) begin
      // Action zero keeps running; any other value shuts down
      shut_vec[i] = fault_vec[i] && (cfg[i][`FRM_ACT_MSB:`FRM_ACT_LSB] != 2'b00);
      if (shut_vec[i]) begin
        shut_retry = cfg[i][`FRM_RETRY_MSB:`FRM_RETRY_LSB];
      end
    end
    shut = |shut_vec;
  end

  // ----------------------------------------------------------------
  // Channel state machine
  // ----------------------------------------------------------------
  // Next state, wait count, retry capture and restart attempts
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_attempts = attempts;
    next_retry_sel = retry_sel;
    case (state)
      frm_pkg::FRM_ST_OFF: begin
        next_attempts = 3'h0;
        if (cmd_on) begin
          next_state = frm_pkg::FRM_ST_RUN;
        end
      end
      frm_pkg::FRM_ST_RUN: begin
        if (!cmd_on) begin
          // Commanded off or bias lost
          next_state = frm_pkg::FRM_ST_OFF;
        end else if (shut) begin
          next_retry_sel = shut_retry;
          if (seq_off_mode_in) begin
            // Sequence off after the turn-off delay
            next_state = frm_pkg::FRM_ST_SEQ_OFF;
            next_cnt = toff_delay_cyc_in;
          end else if (shut_retry != 3'h0 && attempts < retry_limit_in) begin
            next_state = frm_pkg::FRM_ST_RETRY;
            next_cnt = 16'(`FRM_RETRY_WAIT_CYC);
          end else begin
            // No retry left: stay off until released
            next_state = frm_pkg::FRM_ST_LATCHED;
          end
        end
      end
      frm_pkg::FRM_ST_SEQ_OFF: begin
        if (cnt != 16'h0000) begin
          next_cnt = cnt - 16'h0001;
        end else if (retry_sel != 3'h0 && attempts < retry_limit_in && cmd_on) begin
          next_state = frm_pkg::FRM_ST_RETRY;
          next_cnt = 16'(`FRM_RETRY_WAIT_CYC);
        end else begin
          next_state = frm_pkg::FRM_ST_LATCHED;
        end
      end
      frm_pkg::FRM_ST_RETRY: begin
        if (!cmd_on) begin
          // Commanded off or bias removed ends retrying
          next_state = frm_pkg::FRM_ST_OFF;
          next_attempts = 3'h0;
        end else if (shut) begin
          // Another fault ends retrying
          next_state = frm_pkg::FRM_ST_LATCHED;
        end else if (cnt == 16'h0000) begin
          next_state = frm_pkg::FRM_ST_RUN;
          next_attempts = attempts + 3'h1;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      frm_pkg::FRM_ST_LATCHED: begin
        // Clear-faults has no say here
        if (release_latch) begin
          next_state = frm_pkg::FRM_ST_OFF;
          next_attempts = 3'h0;
        end
      end
      default: begin
        next_state = frm_pkg::FRM_ST_OFF;
      end
    endcase
    next_chan_en = (next_state == frm_pkg::FRM_ST_RUN) ||
                   (next_state == frm_pkg::FRM_ST_SEQ_OFF);
  end

  // Register the channel state
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state <= frm_pkg::FRM_ST_OFF;
      cnt <= 16'h0000;
      attempts <= 3'h0;
      retry_sel <= 3'h0;
      chan_en_out <= 1'b0;
      fault_latched_out <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      attempts <= next_attempts;
      retry_sel <= next_retry_sel;
      chan_en_out <= next_chan_en;
      fault_latched_out <= (next_state == frm_pkg::FRM_ST_LATCHED);
    end
  end

  // ----------------------------------------------------------------
  // Status flags and outputs
  // ----------------------------------------------------------------
  // Sticky flags: clear-faults wipes them, a new event wins
  always_comb begin
    next_sticky = sticky;
    if (clear_faults_in) begin
      next_sticky = '0;
    end
    next_sticky.ot = next_sticky.ot | fault_in.ot;
    next_sticky.ut = next_sticky.ut | fault_in.ut;
    next_sticky.vin_ov = next_sticky.vin_ov | fault_in.vin_ov;
    next_sticky.vin_uv = next_sticky.vin_uv | fault_in.vin_uv;
    next_sticky.ton_max = next_sticky.ton_max | fault_in.ton_max;
    next_sticky.vout_ov = next_sticky.vout_ov | vout_ov_fault_in;
    next_sticky.cml = next_sticky.cml | cml_fault_in;
    next_sticky.busy = next_sticky.busy | busy_in;
  end

  // Summary byte, shared by the read port and the status word
  always_comb begin
    summary = 8'h00;
    summary[`FRM_SB_BUSY] = sticky.busy;
    summary[`FRM_SB_OFF] = !chan_en_out;
    summary[`FRM_SB_VOUT_OV] = sticky.vout_ov;
    summary[`FRM_SB_IOUT_OC] = 1'b0;
    summary[`FRM_SB_VIN_UV] = sticky.vin_uv;
    summary[`FRM_SB_TEMP] = sticky.ot | sticky.ut;
    summary[`FRM_SB_CML] = sticky.cml;
    // Faults outside bits 7..1, or power not good
    summary[`FRM_SB_HIGH] = sticky.ton_max | sticky.vin_ov | !pg_ok;
  end

  // Detailed status bytes, status word, read data and alert
  always_comb begin
    next_word = {sticky.ton_max | sticky.vout_ov, 1'b0,
                 sticky.vin_ov | sticky.vin_uv, 1'b0, !pg_ok, 3'h0,
                 summary};
    next_input = {sticky.vin_ov, 2'b00, sticky.vin_uv,
                  sticky.vin_uv & !chan_en_out, 3'h0};
    next_temp = {sticky.ot, 2'b00, sticky.ut, 4'h0};
    next_vout = {sticky.vout_ov, 4'h0, sticky.ton_max, 2'b00};
    next_alert_n = !(|next_sticky);
    case (reg_sel_in)
      `FRM_SEL_OT: next_rdata = cfg[`FRM_SEL_OT];
      `FRM_SEL_UT: next_rdata = cfg[`FRM_SEL_UT];
      `FRM_SEL_VIN_OV: next_rdata = cfg[`FRM_SEL_VIN_OV];
      `FRM_SEL_VIN_UV: next_rdata = cfg[`FRM_SEL_VIN_UV];
      `FRM_SEL_TON: next_rdata = cfg[`FRM_SEL_TON];
      `FRM_SEL_SUMMARY: next_rdata = summary;
      default: next_rdata = 8'h00;
    endcase
  end

  // Register status and outputs
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sticky <= '0;
      status_word_out <= 16'h0000;
      status_input_out <= 8'h00;
      status_temp_out <= 8'h00;
      status_vout_out <= 8'h00;
      reg_rdata_out <= 8'h00;
      alert_out_n <= 1'b1;
    end else begin
      sticky <= next_sticky;
      status_word_out <= next_word;
      status_input_out <= next_input;
      status_temp_out <= next_temp;
      status_vout_out <= next_vout;
      reg_rdata_out <= next_rdata;
      alert_out_n <= next_alert_n;
    end
  end

endmodule : frm_manager

// ===== rtl/frm_defs.svh
// Constants for the fault response manager: selects, fields, reset values, timing
`ifndef FRM_DEFS_SVH
`define FRM_DEFS_SVH

// ----------------------------------------------------------------
// Register selects on the command port
// ----------------------------------------------------------------
`define FRM_SEL_OT 3'h0
`define FRM_SEL_UT 3'h1
`define FRM_SEL_VIN_OV 3'h2
`define FRM_SEL_VIN_UV 3'h3
`define FRM_SEL_TON 3'h4
`define FRM_SEL_SUMMARY 3'h5
`define FRM_NUM_CFG 5

// ----------------------------------------------------------------
// Response configuration byte layout
// ----------------------------------------------------------------
`define FRM_ACT_MSB 7
`define FRM_ACT_LSB 6
`define FRM_RETRY_MSB 5
`define FRM_RETRY_LSB 3
`define FRM_CFG_WMASK 8'hf8
`define FRM_CFG_RST 8'h80

// ----------------------------------------------------------------
// Summary status bit positions
// ----------------------------------------------------------------
`define FRM_SB_BUSY 7
`define FRM_SB_OFF 6
`define FRM_SB_VOUT_OV 5
`define FRM_SB_IOUT_OC 4
`define FRM_SB_VIN_UV 3
`define FRM_SB_TEMP 2
`define FRM_SB_CML 1
`define FRM_SB_HIGH 0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FRM_CLK_MHZ 10
`define FRM_RETRY_WAIT_US 100
`define FRM_RETRY_WAIT_CYC (`FRM_RETRY_WAIT_US * `FRM_CLK_MHZ)

`endif

// ===== rtl/frm_pkg.sv
// Types shared by the fault response manager files
package frm_pkg;

  // Converter-path and timeout fault events, one-cycle pulses
  typedef struct packed {
    logic ton_max;
    logic vin_uv;
    logic vin_ov;
    logic ut;
    logic ot;
  } frm_fault_t;

  // Sticky status flags held until clear-faults
  typedef struct packed {
    logic ot;
    logic ut;
    logic vin_ov;
    logic vin_uv;
    logic ton_max;
    logic vout_ov;
    logic cml;
    logic busy;
  } frm_sticky_t;

  // Channel control states
  typedef enum logic [2:0] {
    FRM_ST_OFF,
    FRM_ST_RUN,
    FRM_ST_SEQ_OFF,
    FRM_ST_RETRY,
    FRM_ST_LATCHED
  } frm_state_t;

endpackage : frm_pkg

// ===== rtl/frm_cfg_reg.sv
// One fault response configuration byte with its own write decode
`timescale 1ns/1ps
`include "frm_defs.svh"

module frm_cfg_reg #(
  parameter logic [2:0] SEL = 3'h0
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic wr_in,
  input wire logic [2:0] sel_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] cfg_out
);

  logic [7:0] next_cfg; // Next configuration value

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  always_comb begin
    next_cfg = cfg_out;
    if (wr_in && (sel_in == SEL)) begin
      // Delay field always stays zero
      next_cfg = wdata_in & `FRM_CFG_WMASK;
    end
  end

  // Register the byte
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cfg_out <= `FRM_CFG_RST;
    end else begin
      cfg_out <= next_cfg;
    end
  end

endmodule : frm_cfg_reg

// ===== tb/frm_manager_props.sv
// Concurrent checks on the fault response manager ports
`timescale 1ns/1ps

module frm_manager_props (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire frm_pkg::frm_fault_t fault_in,
  input wire logic clear_faults_in,
  input wire logic op_wr_in,
  input wire logic on_off_cfg_wr_in,
  input wire logic channel_on_pin_in,
  input wire logic bias_sense_pin_in,
  input wire logic power_good_pin_in,
  input wire logic [2:0] reg_sel_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic chan_en_out,
  input wire logic fault_latched_out,
  input wire logic [15:0] status_word_out,
  input wire logic [7:0] status_input_out,
  input wire logic [7:0] status_temp_out,
  input wire logic [7:0] status_vout_out,
  input wire logic alert_out_n
);
  // ----------------------------------------
  // Clocking and reset for every check
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  // ----------------------------------------
  // Status, alert, channel and register read checks
  // ----------------------------------------
  a_ot_sets_temp: assert property (fault_in.ot |-> ##2 status_word_out[2] && status_temp_out[7])
    else $error("temperature bits missing after fault");
  a_uv_sets_input: assert property (fault_in.vin_uv |-> ##2 status_word_out[3] &&
    status_word_out[13] && status_input_out[4]) else $error("input bits missing after fault");
  a_timeout_sets_vout: assert property (fault_in.ton_max |-> ##2 status_word_out[15] &&
    status_word_out[0] && status_vout_out[2]) else $error("timeout bits missing");
  a_fault_pulls_alert: assert property (fault_in != '0 |-> ##2 !alert_out_n)
    else $error("alert not pulled after fault");
  a_clear_wipes_status: assert property (clear_faults_in && fault_in == '0 |-> ##2
    status_temp_out == 8'h00 && !status_vout_out[2]) else $error("status kept after clear");
  a_iout_bits_zero: assert property (!status_word_out[4] && !status_word_out[14])
    else $error("unsupported current bit set");
  a_off_bit_tracks: assert property ($stable(chan_en_out) && $past(resetn_in) |->
    status_word_out[6] == !chan_en_out) else $error("off bit disagrees with enable");
  a_latched_stays_off: assert property (fault_latched_out |-> !chan_en_out)
    else $error("channel on while latched");
  a_clear_keeps_latch: assert property (fault_latched_out && clear_faults_in && !op_wr_in &&
    !on_off_cfg_wr_in && $stable(channel_on_pin_in) && $stable(bias_sense_pin_in) |=>
    fault_latched_out) else $error("clear released the latch");
  a_delay_reads_zero: assert property (reg_sel_in < 3'h5 |=> reg_rdata_out[2:0] == 3'h0)
    else $error("delay field not zero");
  a_pg_sets_high: assert property (!power_good_pin_in [*5] |-> status_word_out[11] &&
    status_word_out[0]) else $error("power not good not reported");

  // Main scenarios reached
  c_latch: cover property ($rose(fault_latched_out));
  c_alert: cover property ($fell(alert_out_n));
  c_clear_latched: cover property (clear_faults_in && fault_latched_out);
endmodule : frm_manager_props

bind frm_manager frm_manager_props props_u (.clk_in, .resetn_in, .fault_in, .clear_faults_in,
  .op_wr_in, .on_off_cfg_wr_in, .channel_on_pin_in, .bias_sense_pin_in, .power_good_pin_in,
  .reg_sel_in, .reg_rdata_out, .chan_en_out, .fault_latched_out, .status_word_out,
  .status_input_out, .status_temp_out, .status_vout_out, .alert_out_n);

// ===== tb/frm_host_model.sv
// Host model: register accesses, operation command and clear-faults
`timescale 1ns/1ps

module frm_host_model (
  input wire logic clk_in,
  input wire logic [7:0] reg_rdata_out,
  output logic reg_wr_in,
  output logic [2:0] reg_sel_in,
  output logic [7:0] reg_wdata_in,
  output logic op_on_in,
  output logic op_wr_in,
  output logic on_off_cfg_wr_in,
  output logic clear_faults_in
);
  // Idle bus and commands off at time zero
  initial begin
    reg_wr_in = 1'b0;
    reg_sel_in = 3'h0;
    reg_wdata_in = 8'h00;
    op_on_in = 1'b0;
    op_wr_in = 1'b0;
    on_off_cfg_wr_in = 1'b0;
    clear_faults_in = 1'b0;
  end

  // Write one byte; held across the sampling edge
  task automatic wr(input logic [2:0] sel, input logic [7:0] data);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_sel_in <= sel;
    reg_wdata_in <= data;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  // Read one byte; data trails the select by one cycle
  task automatic rd(input logic [2:0] sel, output logic [7:0] data);
    @(posedge clk_in);
    reg_sel_in <= sel;
    repeat (2) @(posedge clk_in);
    #1 data = reg_rdata_out;
  endtask : rd

  // One-cycle command: operation write when op is set, else clear-faults
  task automatic pulse(input logic op, input logic on);
    @(posedge clk_in);
    op_on_in <= on;
    if (op) begin
      op_wr_in <= 1'b1;
    end else begin
      clear_faults_in <= 1'b1;
    end
    @(posedge clk_in);
    op_wr_in <= 1'b0;
    clear_faults_in <= 1'b0;
  endtask : pulse

  // One-cycle on/off configuration write; frees a latched fault
  task automatic cfg_wr();
    @(posedge clk_in);
    on_off_cfg_wr_in <= 1'b1;
    @(posedge clk_in);
    on_off_cfg_wr_in <= 1'b0;
  endtask : cfg_wr
endmodule : frm_host_model

// ===== tb/adc_fault_response_manager_tb.sv
// Self-checking bench for the fault response manager
`timescale 1ns/1ps
`include "frm_defs.svh"

module adc_fault_response_manager_tb;
  // ----------------------------------------
  // Signals, counters and expectations
  // ----------------------------------------
  logic clk_in, resetn_in, vout_ov_fault_in, cml_fault_in, busy_in, seq_off_mode_in;
  logic channel_on_pin_in, bias_sense_pin_in, power_good_pin_in, chan_en_out, alert_out_n;
  logic reg_wr_in, op_on_in, op_wr_in, on_off_cfg_wr_in, clear_faults_in, fault_latched_out;
  logic [2:0] retry_limit_in, reg_sel_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, status_input_out, status_temp_out, status_vout_out;
  logic [15:0] toff_delay_cyc_in, status_word_out;
  frm_pkg::frm_fault_t fault_in;
  logic [7:0] d;
  int n_mismatch = 0;
  int n_compared = 0;
  int n;
  // Expected {word, input, temp, vout}: ot ut vin_ov vin_uv timeout vout_ov cml busy
  logic [39:0] exp_tab [8] = '{40'h0004008000, 40'h0004001000, 40'h2001800000,
    40'h2008100000, 40'h8001000004, 40'h8020000080, 40'h0002000000, 40'h0080000000};

  frm_manager dut_u (.clk_in, .resetn_in, .fault_in, .vout_ov_fault_in, .cml_fault_in,
    .busy_in, .seq_off_mode_in, .toff_delay_cyc_in, .retry_limit_in, .op_on_in, .op_wr_in,
    .on_off_cfg_wr_in, .clear_faults_in, .channel_on_pin_in, .bias_sense_pin_in,
    .power_good_pin_in, .reg_wr_in, .reg_sel_in, .reg_wdata_in, .reg_rdata_out, .chan_en_out,
    .fault_latched_out, .status_word_out, .status_input_out, .status_temp_out,
    .status_vout_out, .alert_out_n);
  frm_host_model host_u (.clk_in, .reg_rdata_out, .reg_wr_in, .reg_sel_in, .reg_wdata_in,
    .op_on_in, .op_wr_in, .on_off_cfg_wr_in, .clear_faults_in);

  // 10 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic finish_test();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [39:0] st();
    return {status_word_out, status_input_out, status_temp_out, status_vout_out};
  endfunction : st

  // One-cycle event: 0..4 fault bits, 5 vout_ov, 6 cml, 7 busy
  task automatic ev(input int i);
    @(posedge clk_in);
    if (i < 5) begin
      fault_in <= frm_pkg::frm_fault_t'(5'h1 << i);
    end else begin
      {busy_in, cml_fault_in, vout_ov_fault_in} <= 3'h1 << (i - 5);
    end
    @(posedge clk_in);
    fault_in <= '0;
    {busy_in, cml_fault_in, vout_ov_fault_in} <= 3'h0;
  endtask : ev

  // Bounded wait for the channel enable to reach a level
  task automatic wait_en(input logic v, input int lim, output int cnt);
    cnt = 0;
    while (chan_en_out !== v) begin
      @(posedge clk_in);
      #1 cnt++;
      if (cnt > lim) begin
        n_mismatch++;
        finish_test();
      end
    end
  endtask : wait_en

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    for (int s = 0; s < 7; s++) begin
      host_u.rd(3'(s), d);
      chk("reset value", d, (s < 5) ? 8'h80 : (s == 5) ? 8'h40 : 8'h00);
      host_u.wr(3'(s), 8'hff);
      host_u.rd(3'(s), d);
      chk("written value", d, (s < 5) ? 8'hf8 : (s == 5) ? 8'h40 : 8'h00);
    end
  endtask : t_regs

  task automatic t_status();
    for (int s = 0; s < 5; s++) host_u.wr(3'(s), 8'h00);
    host_u.pulse(1'b1, 1'b1);
    wait_en(1'b1, 20, n);
    for (int i = 0; i < 8; i++) begin
      ev(i);
      repeat (2) @(posedge clk_in);
      #1 chk("status", st(), exp_tab[i]);
      chk("alert low", alert_out_n, 1'b0);
      chk("still running", chan_en_out, 1'b1);
      host_u.rd(`FRM_SEL_SUMMARY, d);
      chk("summary", d, exp_tab[i][31:24]);
      host_u.pulse(1'b0, 1'b1);
      repeat (2) @(posedge clk_in);
      #1 chk("cleared", {alert_out_n, st()}, {1'b1, 40'h0});
    end
    @(posedge clk_in);
    power_good_pin_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    #1 chk("power not good", {alert_out_n, status_word_out}, {1'b1, 16'h0801});
    @(posedge clk_in);
    power_good_pin_in <= 1'b1;
    repeat (5) @(posedge clk_in);
  endtask : t_status

  task automatic t_latch();
    host_u.wr(`FRM_SEL_OT, 8'h80);
    ev(0);
    @(posedge clk_in);
    #1 chk("shut and latched", {chan_en_out, fault_latched_out}, 2'b01);
    host_u.pulse(1'b0, 1'b1);
    repeat (20) @(posedge clk_in);
    #1 chk("latch kept", {chan_en_out, fault_latched_out, alert_out_n}, 3'b011);
    host_u.pulse(1'b1, 1'b1);
    wait_en(1'b1, 10, n);
    chk("latch freed", fault_latched_out, 1'b0);
    ev(0);
    repeat (2) @(posedge clk_in);
    #1 chk("latched again", fault_latched_out, 1'b1);
    host_u.cfg_wr();
    wait_en(1'b1, 10, n);
    chk("freed by on-off config", fault_latched_out, 1'b0);
  endtask : t_latch

  task automatic t_retry();
    host_u.wr(`FRM_SEL_UT, 8'h88);
    for (int k = 0; k < 3; k++) begin
      ev(1);
      wait_en(1'b0, 3, n);
      if (k < 2) begin
        wait_en(1'b1, 1100, n);
        chk("retry wait", n >= 1000, 1'b1);
      end
    end
    repeat (2) @(posedge clk_in);
    #1 chk("retries spent", fault_latched_out, 1'b1);
    @(posedge clk_in);
    channel_on_pin_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    channel_on_pin_in <= 1'b1;
    wait_en(1'b1, 20, n);
    ev(1);
    repeat (2) @(posedge clk_in);
    #1 chk("count zeroed", {chan_en_out, fault_latched_out}, 2'b00);
    host_u.pulse(1'b1, 1'b0);
    repeat (1100) @(posedge clk_in);
    #1 chk("retry stopped", chan_en_out, 1'b0);
    host_u.pulse(1'b1, 1'b1);
    wait_en(1'b1, 20, n);
    host_u.pulse(1'b0, 1'b1);
  endtask : t_retry

  task automatic t_seq();
    @(posedge clk_in);
    seq_off_mode_in <= 1'b1;
    host_u.wr(`FRM_SEL_TON, 8'h40);
    ev(4);
    repeat (3) @(posedge clk_in);
    #1 chk("sequencing off", chan_en_out, 1'b1);
    wait_en(1'b0, 10, n);
    repeat (2) @(posedge clk_in);
    #1 chk("timeout latched", fault_latched_out, 1'b1);
    @(posedge clk_in);
    bias_sense_pin_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    bias_sense_pin_in <= 1'b1;
    wait_en(1'b1, 20, n);
    // Two faults at once: the lower index (no retry) decides
    host_u.wr(`FRM_SEL_TON, 8'h48);
    @(posedge clk_in);
    fault_in <= frm_pkg::frm_fault_t'(5'h11);
    @(posedge clk_in);
    fault_in <= '0;
    wait_en(1'b0, 10, n);
    repeat (2) @(posedge clk_in);
    #1 chk("lowest index retry", fault_latched_out, 1'b1);
    host_u.pulse(1'b1, 1'b1);
    wait_en(1'b1, 10, n);
    // Sequenced shutdown with retry set goes on to a restart wait
    ev(4);
    wait_en(1'b0, 10, n);
    repeat (2) @(posedge clk_in);
    #1 chk("retry after sequencing", {chan_en_out, fault_latched_out}, 2'b00);
  endtask : t_seq

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn_in = 1'b0;
    fault_in = '0;
    {vout_ov_fault_in, cml_fault_in, busy_in, seq_off_mode_in} = 4'h0;
    {channel_on_pin_in, bias_sense_pin_in, power_good_pin_in} = 3'h7;
    toff_delay_cyc_in = 16'h0005;
    retry_limit_in = 3'h2;
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_regs();
    t_status();
    t_latch();
    t_retry();
    t_seq();
    finish_test();
  end
endmodule : adc_fault_response_manager_tb
